// >>> core/cwd_pwp_decode.v
// Turns the program flash write-lock code into a protected boundary.
// Assumes a static code; pure combinational logic.
`timescale 1ns/100ps
`include "cwd_map.vh"
module cwd_pwp_decode (
  input  wire [5:0]  lock_code,
  output reg  [15:0] boundary,
  output reg         lock_on
);
  reg [5:0] steps;
  // ----------------------------------------
  // Boundary decode.
  // ----------------------------------------
  always @* begin
    steps    = `CWD_PWP_OFF - lock_code;
    lock_on  = (lock_code != `CWD_PWP_OFF);
    boundary = 16'h0000;
    if (lock_code < `CWD_PWP_MAX) begin
      boundary = `CWD_PWP_TOP;
    end else begin
      boundary = {steps, 10'h000};
    end
  end
endmodule

// >>> core/cwd_top.v
// Configuration word decoder: latches two words after reset release, decodes them, APB slave.
// Assumes nvm words are static pins from outside the clock domain.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "cwd_map.vh"
module cwd_top (
  input  wire                  mclk,
  input  wire                  reset_n,
  input  wire [31:0]           nvm_word0,
  input  wire [31:0]           nvm_word1,
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [`CWD_ADDR_W-1:0] paddr,
  input  wire [31:0]           pwdata,
  output wire                  pready,
  output reg  [31:0]           prdata_ff,
  output wire                  pslverr,
  input  wire                  pfm_wr_req,
  input  wire [15:0]           pfm_wr_addr,
  output wire                  pfm_wr_block,
  output wire                  boot_wr_block,
  output wire                  ext_prog_block,
  output wire                  code_protect,
  output wire [15:0]           pfm_boundary,
  output wire [3:0]            programming_pin_pair_sel,
  output wire                  boundary_port_enable,
  output wire                  debugger_enable,
  output wire [2:0]            watchdog_window_eighths,
  output wire                  watchdog_run,
  output wire                  watchdog_window_mode,
  output wire [4:0]            watchdog_postscale,
  output wire [1:0]            peripheral_bus_div_log2,
  output wire [3:0]            primary_osc_mode_sel,
  output wire                  clock_switch_enable,
  output wire                  fail_safe_monitor_enable,
  output wire [7:0]            oscillator_source_sel,
  output wire                  clock_out_pin_enable,
  output wire                  two_speed_startup_enable,
  output wire                  secondary_oscillator_enable,
  output wire                  config_loaded
);

  // ----------------------------------------
  // Loader states.
  // ----------------------------------------
  localparam [1:0] ST_SYNC = 2'b00;
  localparam [1:0] ST_WR0  = 2'b01;
  localparam [1:0] ST_WR1  = 2'b10;
  localparam [1:0] ST_DONE = 2'b11;

  // ----------------------------------------
  // Synchroniser and loader registers.
  // ----------------------------------------
  reg  [63:0] sync1_ff;
  reg  [63:0] sync2_ff;
  reg  [63:0] sync3_ff;
  reg  [1:0]  state_ff;
  reg  [1:0]  nxt_state;
  reg  [3:0]  settle_ff;
  reg  [3:0]  nxt_settle;
  reg         st_wr_en;
  reg         st_wr_sel;
  reg  [31:0] st_wr_data;
  wire [31:0] word0;
  wire [31:0] word1;

  // ----------------------------------------
  // Run-time and bus signals.
  // ----------------------------------------
  reg         rt_jtag_ff;
  reg         wdog_sw_en_ff;
  reg  [31:0] rd_mux;
  reg         addr_ok;
  wire        stable;
  wire        wr_xfer;

  // ----------------------------------------
  // Decode signals.
  // ----------------------------------------
  wire [15:0] pfm_bound_w;
  wire        pfm_lock_on;
  wire [1:0]  dbg_eff;
  wire [4:0]  ps_raw;
  wire [1:0]  fcksm;

  // ----------------------------------------
  // Decode helpers.
  // ----------------------------------------
  function [3:0] cwd_onehot4;
    input [1:0] code;
    begin
      cwd_onehot4       = 4'h0;
      cwd_onehot4[code] = 1'b1;
    end
  endfunction

  // ----------------------------------------
  // Window size in eighths.
  // ----------------------------------------
  function [2:0] cwd_win_eighths;
    input [1:0] code;
    begin
      case (code)
        2'b11:   cwd_win_eighths = 3'h2;
        2'b10:   cwd_win_eighths = 3'h3;
        2'b01:   cwd_win_eighths = 3'h4;
        default: cwd_win_eighths = 3'h6;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Address match.
  // ----------------------------------------
  function cwd_hit;
    input [`CWD_ADDR_W-1:0] a;
    input [`CWD_ADDR_W-1:0] ofs;
    begin
      cwd_hit = (a == ofs);
    end
  endfunction

  // ----------------------------------------
  // Input synchronisers for the storage words.
  // ----------------------------------------
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= 64'h0000000000000000;
      sync2_ff <= 64'h0000000000000000;
      sync3_ff <= 64'h0000000000000000;
    end else begin
      sync1_ff <= {nvm_word1, nvm_word0};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // ----------------------------------------
  // Word stability.
  // ----------------------------------------
  assign stable = (sync2_ff == sync3_ff);

  // ----------------------------------------
  // Loader: capture once after reset release.
  // ----------------------------------------
  always @* begin
    nxt_state  = state_ff;
    nxt_settle = settle_ff;
    st_wr_en   = 1'b0;
    st_wr_sel  = 1'b0;
    st_wr_data = sync3_ff[31:0];
    case (state_ff)
      ST_SYNC: begin
        if (!stable) begin
          nxt_settle = 4'h0;
        end else if (settle_ff == `CWD_SETTLE) begin
          nxt_state = ST_WR0;
        end else begin
          nxt_settle = settle_ff + 4'h1;
        end
      end
      ST_WR0: begin
        st_wr_en  = 1'b1;
        nxt_state = ST_WR1;
      end
      ST_WR1: begin
        st_wr_en   = 1'b1;
        st_wr_sel  = 1'b1;
        st_wr_data = sync3_ff[63:32];
        nxt_state  = ST_DONE;
      end
      ST_DONE: begin
        nxt_state = ST_DONE;
      end
      default: begin
        nxt_state = ST_SYNC;
      end
    endcase
  end

  // ----------------------------------------
  // Loader state register.
  // ----------------------------------------
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff  <= ST_SYNC;
      settle_ff <= 4'h0;
    end else begin
      state_ff  <= nxt_state;
      settle_ff <= nxt_settle;
    end
  end

  assign config_loaded = (state_ff == ST_DONE);

  // ----------------------------------------
  // Latched word storage.
  // ----------------------------------------
  cwd_word_store u_store (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .wr_en    (st_wr_en),
    .wr_sel   (st_wr_sel),
    .wr_data  (st_wr_data),
    .word0_ff (word0),
    .word1_ff (word1)
  );

  // ----------------------------------------
  // Protection and debug decode.
  // ----------------------------------------
  assign code_protect   = ~word0[`CWD_CP_BIT];
  assign ext_prog_block = code_protect;
  assign boot_wr_block  = ~word0[`CWD_BWP_BIT];

  // ----------------------------------------
  // Program flash write lock.
  // ----------------------------------------
  cwd_pwp_decode u_pwp (
    .lock_code (word0[`CWD_PWP_HI:`CWD_PWP_LO]),
    .boundary  (pfm_bound_w),
    .lock_on   (pfm_lock_on)
  );

  assign pfm_boundary = pfm_lock_on ? pfm_bound_w : 16'h0000;
  assign pfm_wr_block = pfm_wr_req & pfm_lock_on & (pfm_wr_addr < pfm_bound_w);

  // ----------------------------------------
  // Debug channel and JTAG.
  // ----------------------------------------
  assign programming_pin_pair_sel =
    cwd_onehot4(~word0[`CWD_ICE_HI:`CWD_ICE_LO]);

  assign boundary_port_enable = rt_jtag_ff;

  assign dbg_eff = code_protect ? `CWD_DBG_FORCED : word0[`CWD_DBG_HI:`CWD_DBG_LO];
  assign debugger_enable = ~dbg_eff[1];

  // ----------------------------------------
  // Watchdog decode.
  // ----------------------------------------
  assign watchdog_window_eighths =
    cwd_win_eighths(word1[`CWD_WINSZ_HI:`CWD_WINSZ_LO]);
  assign watchdog_run = word1[`CWD_WDTEN_BIT] | wdog_sw_en_ff;
  assign watchdog_window_mode = ~word1[`CWD_WATCHDOG_WINDOW_OFF_BIT];

  // ----------------------------------------
  // Watchdog postscale clamp.
  // ----------------------------------------
  assign ps_raw = word1[`CWD_WDTPS_HI:`CWD_WDTPS_LO];
  assign watchdog_postscale = (ps_raw > `CWD_WDTPS_MAX) ? `CWD_WDTPS_MAX : ps_raw;

  // ----------------------------------------
  // Clock source decode.
  // ----------------------------------------
  assign peripheral_bus_div_log2 = word1[`CWD_PBDIV_HI:`CWD_PBDIV_LO];
  assign primary_osc_mode_sel = cwd_onehot4(word1[`CWD_POSC_HI:`CWD_POSC_LO]);

  // ----------------------------------------
  // Clock switch and monitor.
  // ----------------------------------------
  assign fcksm = word1[`CWD_FCKSM_HI:`CWD_FCKSM_LO];
  assign clock_switch_enable      = ~fcksm[1];
  assign fail_safe_monitor_enable = (fcksm == 2'b00);

  // ----------------------------------------
  // Oscillator source one-hot.
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `CWD_FNOSC_CODES; gi = gi + 1) begin : g_src
      assign oscillator_source_sel[gi] =
        ({`CWD_FNOSC_PAD, word1[`CWD_FNOSC_HI:`CWD_FNOSC_LO]} == gi);
    end
  endgenerate

  // ----------------------------------------
  // Auxiliary clock options.
  // ----------------------------------------
  assign clock_out_pin_enable        = ~word1[`CWD_CLKO_BIT];
  assign two_speed_startup_enable    = word1[`CWD_TWO_SPEED_STARTUP_ENABLE_BIT];
  assign secondary_oscillator_enable = word1[`CWD_SOSC_BIT];

  // ----------------------------------------
  // APB slave.
  // ----------------------------------------
  assign pready  = config_loaded;
  assign wr_xfer = psel & penable & pready & pwrite & addr_ok;
  assign pslverr = psel & penable & pready & ~addr_ok;

  // ----------------------------------------
  // Read decode.
  // ----------------------------------------
  always @* begin
    addr_ok = 1'b1;
    rd_mux  = 32'h00000000;
    if (cwd_hit(paddr, `CWD_OFS_WORD0)) begin
      rd_mux = word0;
    end else if (cwd_hit(paddr, `CWD_OFS_WORD1)) begin
      rd_mux = word1;
    end else if (cwd_hit(paddr, `CWD_OFS_RTCC)) begin
      rd_mux[`CWD_RT_JTAG_BIT] = rt_jtag_ff;
    end else if (cwd_hit(paddr, `CWD_OFS_WDOG)) begin
      rd_mux[`CWD_WDOG_SW_BIT]  = wdog_sw_en_ff;
      rd_mux[`CWD_WDOG_RUN_BIT] = watchdog_run;
    end else if (cwd_hit(paddr, `CWD_OFS_STAT)) begin
      rd_mux[`CWD_STAT_LD_BIT]  = config_loaded;
      rd_mux[`CWD_STAT_CP_BIT]  = code_protect;
      rd_mux[`CWD_STAT_DBG_BIT] = debugger_enable;
      rd_mux[`CWD_STAT_PS_HI:`CWD_STAT_PS_LO] = watchdog_postscale;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // ----------------------------------------
  // Read data register.
  // ----------------------------------------
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_ff <= 32'h00000000;
    end else if (psel & ~pwrite) begin
      prdata_ff <= rd_mux;
    end
  end

  // ----------------------------------------
  // Run-time JTAG enable register.
  // ----------------------------------------
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rt_jtag_ff <= 1'b0;
    end else if (state_ff == ST_WR0) begin
      rt_jtag_ff <= sync3_ff[`CWD_JTAG_BIT];
    end else if (wr_xfer & cwd_hit(paddr, `CWD_OFS_RTCC)) begin
      rt_jtag_ff <= pwdata[`CWD_RT_JTAG_BIT];
    end
  end

  // ----------------------------------------
  // Watchdog software enable register.
  // ----------------------------------------
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wdog_sw_en_ff <= 1'b0;
    end else if (wr_xfer & cwd_hit(paddr, `CWD_OFS_WDOG)) begin
      wdog_sw_en_ff <= pwdata[`CWD_WDOG_SW_BIT];
    end
  end

endmodule

// >>> core/cwd_word_store.v
// Holds the two latched configuration words.
// Assumes one write per cycle; outputs come from registers.
`timescale 1ns/100ps
`include "cwd_map.vh"
module cwd_word_store (
  input  wire        mclk,
  input  wire        reset_n,
  input  wire        wr_en,
  input  wire        wr_sel,
  input  wire [31:0] wr_data,
  output reg  [31:0] word0_ff,
  output reg  [31:0] word1_ff
);
  // ----------------------------------------
  // Storage.
  // ----------------------------------------
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      word0_ff <= `CWD_WORD_RST;
      word1_ff <= `CWD_WORD_RST;
    end else if (wr_en) begin
      if (wr_sel) begin
        word1_ff <= wr_data;
      end else begin
        word0_ff <= wr_data;
      end
    end
  end
endmodule

// >>> dv/cwd_assertions.sv
// Checker of the configuration word decoder at the top ports.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/100ps
module cwd_assertions (
  input logic        mclk,
  input logic        reset_n,
  input logic [31:0] nvm_word0,
  input logic [31:0] nvm_word1,
  input logic        psel,
  input logic        penable,
  input logic        pslverr,
  input logic        pfm_wr_req,
  input logic [15:0] pfm_wr_addr,
  input logic        pfm_wr_block,
  input logic        boot_wr_block,
  input logic        ext_prog_block,
  input logic        code_protect,
  input logic [15:0] pfm_boundary,
  input logic [3:0]  programming_pin_pair_sel,
  input logic        boundary_port_enable,
  input logic        debugger_enable,
  input logic        watchdog_run,
  input logic        watchdog_window_mode,
  input logic [4:0]  watchdog_postscale,
  input logic        config_loaded
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_loading;
    !config_loaded [*8];
  endsequence
  sequence s_loaded;
    $rose(config_loaded);
  endsequence
  load_time_a:
    assert property ($rose(reset_n) |-> s_loading ##[1:20] config_loaded)
    else $error("load not finished in time");
  prot_decode_a:
    assert property (s_loaded |-> ext_prog_block == !nvm_word0[28]
      && code_protect == !nvm_word0[28] && boot_wr_block == !nvm_word0[24])
    else $error("protection decode wrong");
  debug_force_a:
    assert property (s_loaded |-> debugger_enable == (nvm_word0[28] && !nvm_word0[1]))
    else $error("debugger enable wrong");
  pin_pair_a:
    assert property (s_loaded |-> programming_pin_pair_sel == 4'h1 << (2'h3 - nvm_word0[4:3]))
    else $error("pin pair select wrong");
  jtag_seed_a:
    assert property (s_loaded |-> boundary_port_enable == nvm_word0[2])
    else $error("jtag enable seed wrong");
  wdog_mode_a:
    assert property (s_loaded |-> watchdog_run == nvm_word1[23]
      && watchdog_window_mode == !nvm_word1[22])
    else $error("watchdog mode wrong");
  post_clamp_a:
    assert property (s_loaded |-> watchdog_postscale ==
      ((nvm_word1[20:16] > 5'h14) ? 5'h14 : nvm_word1[20:16]))
    else $error("postscale wrong");
  settings_hold_a:
    assert property (config_loaded && $past(config_loaded) |->
      $stable(code_protect) && $stable(pfm_boundary) && $stable(watchdog_postscale))
    else $error("settings changed after load");
  write_block_a:
    assert property (pfm_wr_block == (pfm_wr_req && pfm_wr_addr < pfm_boundary))
    else $error("flash write block wrong");
  slverr_phase_a:
    assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
endmodule

bind cwd_top cwd_assertions cwd_assertions_inst (.mclk, .reset_n, .nvm_word0, .nvm_word1,
  .psel, .penable, .pslverr, .pfm_wr_req, .pfm_wr_addr, .pfm_wr_block, .boot_wr_block,
  .ext_prog_block, .code_protect, .pfm_boundary, .programming_pin_pair_sel,
  .boundary_port_enable, .debugger_enable, .watchdog_run, .watchdog_window_mode,
  .watchdog_postscale, .config_loaded);

// >>> dv/cwd_prog_model.sv
// Programmer model: turns field values into stored configuration words.
// Assumes the bench changes fields while the decoder is in reset, apart from the final hold check.
`timescale 1ns/100ps
module cwd_prog_model (
  input  logic [31:0] fields0,
  input  logic [31:0] fields1,
  output logic [31:0] nvm_word0,
  output logic [31:0] nvm_word1
);
  // ----------------------------------------
  // Word assembly
  // ----------------------------------------
  logic [1:0] posc;
  assign posc = ((fields1[2:0] == 3'h2 || fields1[2:0] == 3'h3) && fields1[9:8] == 2'h3)
                ? 2'h2 : fields1[9:8];
  assign nvm_word0 = (fields0 & 32'h1100fc1f) | 32'h6eff03e0;
  assign nvm_word1 = {fields1[31:10] & 22'h00f7fd, posc, fields1[7:0] & 8'ha7}
                     | 32'hfc200858;
endmodule

// >>> dv/tb_top.sv
// Testbench of the configuration word decoder.
// Assumes the decoder reloads its words on every reset.
`include "cwd_map.vh"
`timescale 1ns/100ps
module tb_top;
  logic mclk, reset_n, psel, penable, pwrite, pfm_wr_req;
  logic [`CWD_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, nvm_word0, nvm_word1, f0, f1, rd;
  logic [15:0] pfm_wr_addr, eb;
  logic er, cp, boot_flash_write_lock, jtag, wdt, wdis;
  logic [1:0] ice, dbg, winsz, fck, pbd, posc;
  logic [2:0] fn, ew;
  logic [3:0] epp;
  logic [4:0] ps, eps;
  logic [5:0] pwp;
  logic [31:0] prdata_ff;
  logic pready, pslverr, pfm_wr_block, boot_wr_block, ext_prog_block, code_protect;
  logic [15:0] pfm_boundary;
  logic [3:0] programming_pin_pair_sel, primary_osc_mode_sel;
  logic boundary_port_enable, debugger_enable, watchdog_run, watchdog_window_mode;
  logic [2:0] watchdog_window_eighths;
  logic [4:0] watchdog_postscale;
  logic [1:0] peripheral_bus_div_log2;
  logic clock_switch_enable, fail_safe_monitor_enable, config_loaded;
  logic clock_out_pin_enable, two_speed_startup_enable, secondary_oscillator_enable;
  logic [7:0] oscillator_source_sel;
  int failures, num_checks;

  cwd_top cwd_top_inst (.mclk, .reset_n, .nvm_word0, .nvm_word1, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata_ff, .pslverr, .pfm_wr_req, .pfm_wr_addr,
    .pfm_wr_block, .boot_wr_block, .ext_prog_block, .code_protect, .pfm_boundary,
    .programming_pin_pair_sel, .boundary_port_enable, .debugger_enable,
    .watchdog_window_eighths, .watchdog_run, .watchdog_window_mode, .watchdog_postscale,
    .peripheral_bus_div_log2, .primary_osc_mode_sel, .clock_switch_enable,
    .fail_safe_monitor_enable, .oscillator_source_sel, .clock_out_pin_enable,
    .two_speed_startup_enable, .secondary_oscillator_enable, .config_loaded);
  cwd_prog_model cwd_prog_model_inst (.fields0(f0), .fields1(f1), .nvm_word0, .nvm_word1);

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task complete_run;
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task apb(input logic w, input logic [`CWD_ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata_ff;
    er = pslverr;
    if (n >= 100) begin
      failures++;
      complete_run;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task load(input logic [5:0] k);
    int n;
    {pwp, cp, boot_flash_write_lock, jtag, ice, dbg} = {k, k[2], k[3], k[4], k[1:0], k[0], k[3]};
    {winsz, wdt, wdis, ps, fck, pbd, posc} = {k[1:0], k[2], k[3], k[4:0], k[5:4], k[3:0]};
    fn = k[5:3] | {k[1] & k[0], 2'h0};
    eb = (pwp == 6'h3f) ? 16'h0 : (pwp < 6'h1f) ? 16'h8000 : {6'h3f - pwp, 10'h0};
    ew = (winsz == 2'h0) ? 3'h6 : 3'h5 - {1'b0, winsz};
    eps = (ps > 5'h14) ? 5'h14 : ps;
    epp = 4'h1 << (2'h3 - ice);
    @(posedge mclk);
    reset_n <= 1'b0;
    f0 <= {3'h0, cp, 3'h0, boot_flash_write_lock, 8'h0, pwp, 5'h0, ice, jtag, dbg};
    f1 <= {6'h0, winsz, wdt, wdis, 1'b0, ps, fck, pbd, 1'b0, k[5], posc, k[4], 1'b0, k[0],
      2'h0, fn};
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (config_loaded !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      complete_run;
    end
    @(negedge mclk);
  endtask

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    {reset_n, psel, penable, pwrite, pfm_wr_req} = 5'h0;
    {paddr, pwdata, pfm_wr_addr, f0, f1} = '0;
    failures = 0;
    num_checks = 0;
    for (int i = 0; i < 64; i++) begin
      load(i[5:0]);
      chk("prot", {ext_prog_block, boot_wr_block, code_protect, debugger_enable,
        programming_pin_pair_sel, boundary_port_enable},
        {~cp, ~boot_flash_write_lock, ~cp, cp & ~dbg[1], epp, jtag});
      chk("boundary", pfm_boundary, eb);
      chk("wdog", {watchdog_window_eighths, watchdog_run, watchdog_window_mode,
        watchdog_postscale}, {ew, wdt, ~wdis, eps});
      chk("clock", {peripheral_bus_div_log2, primary_osc_mode_sel, clock_switch_enable,
        fail_safe_monitor_enable, oscillator_source_sel, clock_out_pin_enable,
        two_speed_startup_enable, secondary_oscillator_enable},
        {pbd, 4'h1 << posc, ~fck[1], fck == 2'h0, 8'h1 << fn, ~f1[10], f1[7],
        f1[5]});
      @(posedge mclk);
      pfm_wr_req <= 1'b1;
      pfm_wr_addr <= eb - 16'h1;
      @(negedge mclk);
      chk("below", pfm_wr_block, eb != 16'h0);
      @(posedge mclk);
      pfm_wr_addr <= eb;
      @(negedge mclk);
      chk("at_bound", pfm_wr_block, 1'b0);
    end
    load(6'h13);
    apb(1'b0, `CWD_OFS_WORD0, 32'h0);
    chk("word0", rd, (f0 & 32'h1100fc1f) | 32'h6eff03e0);
    apb(1'b0, `CWD_OFS_RTCC, 32'h0);
    chk("rt_jtag", rd[`CWD_RT_JTAG_BIT], 1'b1);
    apb(1'b1, `CWD_OFS_RTCC, 32'h0);
    @(negedge mclk);
    chk("jtag_off", boundary_port_enable, 1'b0);
    apb(1'b1, `CWD_OFS_WDOG, 32'h1);
    @(negedge mclk);
    chk("sw_wdog", watchdog_run, 1'b1);
    apb(1'b0, 5'h14, 32'h0);
    chk("unmapped", {er, rd}, {1'b1, 32'h0});
    load(6'h17);
    apb(1'b1, `CWD_OFS_WDOG, 32'h0);
    @(negedge mclk);
    chk("fuse_wdog", watchdog_run, 1'b1);
    f0 <= f0 ^ 32'h1000fc00;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    chk("held", {pfm_boundary, code_protect}, {eb, ~cp});
    complete_run;
  end
endmodule

// >>> inc/cwd_map.vh
// Constants of the configuration word decoder: bit fields, register map, loader timing.
// Assumes the two words arrive as static levels from nonvolatile storage.
// What this block does
// - Code-protect 0 blocks external programmer flash access.
// - Boot write-lock 0 blocks run-time boot writes.
// - Write-lock all ones disables program flash protection.
// - Each step down raises boundary by 0x0400, up to 0x8000.
// - Channel field routes debugger to one pin pair.
// - Boundary-port bit turns JTAG on or off.
// - JTAG bit seeds the run-time control register.
// - Debugger upper bit one disables background debugger.
// - Code protection forces debugger field to 11.
// - Window-size field selects 25, 37.5, 50, 75%.
// - Fuse enable runs watchdog, software cannot stop.
// - Window-off bit selects non-window or window mode.
// - Postscale divides by two to the code.
// - Codes above 10100 act as 10100.
// - Divider field sets peripheral clock divide 1,2,4,8.
// - Oscillator mode: off, high-speed, crystal, external.
// - Switch field: 1x none, 01 switch, 00 both.
// - Source field selects clock source; 011 primary+PLL.
`ifndef CWD_MAP_VH
`define CWD_MAP_VH

// ----------------------------------------
// Protection and debug word fields
// ----------------------------------------
`define CWD_CP_BIT        28
`define CWD_BWP_BIT       24
`define CWD_PWP_HI        15
`define CWD_PWP_LO        10
`define CWD_ICE_HI        4
`define CWD_ICE_LO        3
`define CWD_JTAG_BIT      2
`define CWD_DBG_HI        1
`define CWD_DBG_LO        0
`define CWD_PWP_OFF       6'h3f
`define CWD_PWP_MAX       6'h1f
`define CWD_PWP_STEP      16'h0400
`define CWD_PWP_TOP       16'h8000
`define CWD_DBG_FORCED    2'h3

// ----------------------------------------
// Clock and watchdog word fields
// ----------------------------------------
`define CWD_WINSZ_HI      25
`define CWD_WINSZ_LO      24
`define CWD_WDTEN_BIT     23
`define CWD_WATCHDOG_WINDOW_OFF_BIT    22
`define CWD_WDTPS_HI      20
`define CWD_WDTPS_LO      16
`define CWD_WDTPS_MAX     5'h14
`define CWD_FCKSM_HI      15
`define CWD_FCKSM_LO      14
`define CWD_PBDIV_HI      13
`define CWD_PBDIV_LO      12
`define CWD_CLKO_BIT      10
`define CWD_POSC_HI       9
`define CWD_POSC_LO       8
`define CWD_TWO_SPEED_STARTUP_ENABLE_BIT      7
`define CWD_SOSC_BIT      5
`define CWD_FNOSC_HI      2
`define CWD_FNOSC_LO      0
`define CWD_FNOSC_CODES   8
`define CWD_FNOSC_PAD     29'h00000000

// ----------------------------------------
// Register map and reset values
// ----------------------------------------
`define CWD_ADDR_W        5
`define CWD_OFS_WORD0     5'h00
`define CWD_OFS_WORD1     5'h04
`define CWD_OFS_RTCC      5'h08
`define CWD_OFS_WDOG      5'h0c
`define CWD_OFS_STAT      5'h10
`define CWD_WORD_RST      32'h00000000
`define CWD_RT_JTAG_BIT   3
`define CWD_WDOG_SW_BIT   0
`define CWD_WDOG_RUN_BIT  1
`define CWD_STAT_LD_BIT   0
`define CWD_STAT_CP_BIT   1
`define CWD_STAT_DBG_BIT  2
`define CWD_STAT_PS_HI    7
`define CWD_STAT_PS_LO    3
`define CWD_SETTLE        4'h8

`endif
